// >>> hw/gpio_port_pkg.sv
// constants and register map of the two pin gpio port
package gpio_port_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] latch_offset = 8'h00;
    localparam logic [7:0] direction_offset = 8'h01;
    localparam logic [7:0] pullup_offset = 8'h02;
    // ************************************************************
    // field layout
    // ************************************************************
    localparam int pin_lo_pos = 1;
    localparam int pin_hi_pos = 2;
    localparam int pin_count = 2;
    localparam logic [7:0] impl_mask = 8'h06;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] latch_reset = 2'h0;
    localparam logic [1:0] direction_reset = 2'h0;
    localparam logic [1:0] pullup_reset = 2'h0;
    localparam logic [7:0] rdata_reset = 8'h00;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int sync_stages = 2;
endpackage

// >>> hw/pin_sync.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // data
    input wire logic async_i,
    output logic sync_o
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
        if (reset_i) begin
            meta_next = 1'b0;
            sync_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_o = sync_reg;
endmodule

// >>> hw/pin_cell.sv
// one port pin: drive, pull-up and standby isolation
`timescale 1ns/1ps
module pin_cell (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // control
    input wire logic latch_i,
    input wire logic dir_i,
    input wire logic pullup_i,
    input wire logic isolate_i,
    input wire logic pin_sync_i,
    // pin side
    output logic pin_o,
    output logic pin_oe_o,
    output logic pullup_on_o,
    output logic pin_level_o
);
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic pu_reg;
    logic pu_next;
    logic lvl_reg;
    logic lvl_next;

    always_comb begin
        out_next = latch_i;
        oe_next = dir_i & ~isolate_i;
        pu_next = pullup_i & ~(oe_next & ~out_next);
        lvl_next = isolate_i ? 1'b0 : pin_sync_i;
        if (reset_i) begin
            out_next = 1'b0;
            oe_next = 1'b0;
            pu_next = 1'b0;
            lvl_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        out_reg <= out_next;
        oe_reg <= oe_next;
        pu_reg <= pu_next;
        lvl_reg <= lvl_next;
    end

    assign pin_o = out_reg;
    assign pin_oe_o = oe_reg;
    assign pullup_on_o = pu_reg;
    assign pin_level_o = lvl_reg;
endmodule

// >>> hw/two_pin_gpio_port.sv
// two pin general purpose port with register slave
// ************************************************************
// ************************************************************
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module two_pin_gpio_port (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic rd_rmw_i,
    output logic [7:0] rdata_o,
    // standby
    input wire logic standby_pin_state_bit_i,
    input wire logic standby_mode_i,
    // pins
    input wire logic [1:0] pin_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o,
    output logic [1:0] pullup_on_o
);
    import gpio_port_pkg::*;

    logic [1:0] port_output_latch_reg;
    logic [1:0] port_output_latch_next;
    logic [1:0] port_direction_reg;
    logic [1:0] port_direction_next;
    logic [1:0] port_pullup_enable_reg;
    logic [1:0] port_pullup_enable_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic isolate_reg;
    logic isolate_next;
    logic [1:0] pin_sync;
    logic [1:0] pin_level;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_pu;
    logic [1:0] wfield;
    logic [1:0] rd_pins;

    // ************************************************************
    // per pin logic
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < pin_count; g = g + 1) begin : gen_pin
            pin_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .async_i(pin_i[g]),
                .sync_o(pin_sync[g])
            );
            pin_cell u_cell (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .latch_i(port_output_latch_reg[g]),
                .dir_i(port_direction_reg[g]),
                .pullup_i(port_pullup_enable_reg[g]),
                .isolate_i(isolate_reg),
                .pin_sync_i(pin_sync[g]),
                .pin_o(pin_out[g]),
                .pin_oe_o(pin_oe[g]),
                .pullup_on_o(pin_pu[g]),
                .pin_level_o(pin_level[g])
            );
        end
    endgenerate

    // ************************************************************
    // registers
    // ************************************************************
    always_comb begin
        wfield = wdata_i[pin_hi_pos:pin_lo_pos];
        port_output_latch_next = port_output_latch_reg;
        port_direction_next = port_direction_reg;
        port_pullup_enable_next = port_pullup_enable_reg;
        // standby with isolation turns off pin drivers but keeps pull-ups, otherwise state held
        isolate_next = standby_mode_i & standby_pin_state_bit_i;
        if (wr_i) begin
            unique case (addr_i)
                latch_offset: port_output_latch_next = wfield;
                direction_offset: port_direction_next = wfield;
                pullup_offset: port_pullup_enable_next = wfield;
                default: ;
            endcase
        end
        if (reset_i) begin
            port_output_latch_next = latch_reset;
            port_direction_next = direction_reset;
            port_pullup_enable_next = pullup_reset;
            isolate_next = 1'b0;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb begin
        rdata_next = rdata_reset;
        rd_pins = (port_direction_reg & port_output_latch_reg)
            | (~port_direction_reg & pin_level);
        if (rd_i) begin
            unique case (addr_i)
                latch_offset: begin
                    if (rd_rmw_i) begin
                        rdata_next[pin_hi_pos:pin_lo_pos] = port_output_latch_reg;
                    end else begin
                        rdata_next[pin_hi_pos:pin_lo_pos] = rd_pins;
                    end
                end
                direction_offset: rdata_next[pin_hi_pos:pin_lo_pos] = port_direction_reg;
                pullup_offset: rdata_next[pin_hi_pos:pin_lo_pos] = port_pullup_enable_reg;
                default: rdata_next = rdata_reset;
            endcase
        end
        if (reset_i) begin
            rdata_next = rdata_reset;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        port_output_latch_reg <= port_output_latch_next;
        port_direction_reg <= port_direction_next;
        port_pullup_enable_reg <= port_pullup_enable_next;
        isolate_reg <= isolate_next;
        rdata_reg <= rdata_next;
    end

    assign rdata_o = rdata_reg;
    assign pin_o = pin_out;
    assign pin_oe_o = pin_oe;
    assign pullup_on_o = pin_pu;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_dir_drive;
        @(posedge clk_sys_i) disable iff (reset_i)
        ##1 (pin_oe_o == $past(port_direction_reg & {2{~isolate_reg}}));
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("oe not from direction");

    property p_latch_out;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == latch_offset) |-> ##2 (pin_o == $past(wdata_i[2:1], 2));
    endproperty
    a_latch_out: assert property (p_latch_out) else $error("pin not latch");

    property p_read_out;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && !rd_rmw_i && addr_i == latch_offset && port_direction_reg == 2'h3)
        |=> (rdata_o[2:1] == $past(port_output_latch_reg));
    endproperty
    a_read_out: assert property (p_read_out) else $error("output read wrong");

    property p_in_nodrive;
        @(posedge clk_sys_i) disable iff (reset_i)
        (port_direction_reg == 2'h0) |=> (pin_oe_o == 2'h0);
    endproperty
    a_in_nodrive: assert property (p_in_nodrive) else $error("input driven");

    property p_read_in;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && !rd_rmw_i && addr_i == latch_offset && port_direction_reg == 2'h0)
        |=> (rdata_o[2:1] == $past(pin_level));
    endproperty
    a_read_in: assert property (p_read_in) else $error("input read wrong");

    property p_rmw;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && rd_rmw_i && addr_i == latch_offset)
        |=> (rdata_o[2:1] == $past(port_output_latch_reg));
    endproperty
    a_rmw: assert property (p_rmw) else $error("rmw read wrong");

    property p_reset_dir;
        @(posedge clk_sys_i) reset_i |=> (port_direction_reg == 2'h0) ##1 (pin_oe_o == 2'h0);
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("reset dir");

    property p_isolate;
        @(posedge clk_sys_i) disable iff (reset_i)
        (standby_mode_i && standby_pin_state_bit_i) [*2] |=>
        (pin_oe_o == 2'h0 && pin_level == 2'h0);
    endproperty
    a_isolate: assert property (p_isolate) else $error("not isolated");

    property p_pull_low;
        @(posedge clk_sys_i) disable iff (reset_i)
        (pin_oe_o & ~pin_o & pullup_on_o) == 2'h0;
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pullup on low out");

    property p_unused_zero;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rdata_o & ~impl_mask) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    // ************************************************************
    // standby, pull-up and bus checks
    // ************************************************************
    property p_keep_state;
        @(posedge clk_sys_i) disable iff (reset_i)
        (standby_mode_i && !standby_pin_state_bit_i && !isolate_reg)
        |=> (pin_oe_o == $past(port_direction_reg) && pin_o == $past(port_output_latch_reg));
    endproperty
    a_keep_state: assert property (p_keep_state) else $error("standby state lost");

    property p_pull_on;
        @(posedge clk_sys_i) disable iff (reset_i)
        (port_pullup_enable_reg == 2'h3 && port_direction_reg == 2'h0)
        |=> (pullup_on_o == 2'h3);
    endproperty
    a_pull_on: assert property (p_pull_on) else $error("pullup not on");

    property p_pull_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        (port_pullup_enable_reg == 2'h0) |=> (pullup_on_o == 2'h0);
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pullup not off");

    property p_latch_write;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == latch_offset)
        |=> (port_output_latch_reg == $past(wdata_i[pin_hi_pos:pin_lo_pos]));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch not written");

    property p_dir_write;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == direction_offset)
        |=> (port_direction_reg == $past(wdata_i[pin_hi_pos:pin_lo_pos]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not written");

    property p_pull_write;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == pullup_offset)
        |=> (port_pullup_enable_reg == $past(wdata_i[pin_hi_pos:pin_lo_pos]));
    endproperty
    a_pull_write: assert property (p_pull_write) else $error("pullup not written");

    property p_ignore_unmapped;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i != latch_offset && addr_i != direction_offset
            && addr_i != pullup_offset)
        |=> ($stable(port_output_latch_reg) && $stable(port_direction_reg)
            && $stable(port_pullup_enable_reg));
    endproperty
    a_ignore_unmapped: assert property (p_ignore_unmapped) else $error("unmapped write");

    property p_unmapped_read;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && addr_i != latch_offset && addr_i != direction_offset
            && addr_i != pullup_offset) |=> (rdata_o == rdata_reset);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

    property p_pin_sync;
        @(posedge clk_sys_i) disable iff (reset_i)
        (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3) && !$past(isolate_reg))
        |-> (pin_level == $past(pin_i, 3));
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin level not synced");

    property p_float_level;
        @(posedge clk_sys_i) disable iff (reset_i)
        isolate_reg |=> (pin_level == 2'h0);
    endproperty
    a_float_level: assert property (p_float_level) else $error("input not blocked");

    property p_reset_regs;
        @(posedge clk_sys_i)
        reset_i |=> (port_output_latch_reg == latch_reset
            && port_pullup_enable_reg == pullup_reset && rdata_o == rdata_reset);
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("reset values wrong");

    c_rmw: cover property (@(posedge clk_sys_i) rd_i && rd_rmw_i);
    c_isolate: cover property (@(posedge clk_sys_i) isolate_reg);
    c_drive: cover property (@(posedge clk_sys_i) pin_oe_o == 2'h3);
    c_hold: cover property (@(posedge clk_sys_i) standby_mode_i && !standby_pin_state_bit_i);
    c_pull: cover property (@(posedge clk_sys_i) pullup_on_o == 2'h3);
endmodule

// >>> test/board_model.sv
// board circuitry model that loads and drives the two port pins
`timescale 1ns/1ps
module board_model (
    // clock
    input wire logic clk_sys_i,
    // device side
    input wire logic [1:0] pin_drive_i,
    input wire logic [1:0] pin_oe_i,
    input wire logic [1:0] pullup_on_i,
    // board side
    input wire logic [1:0] ext_en_i,
    input wire logic [1:0] ext_level_i,
    output logic [1:0] pin_level_o
);
    // ************************************************************
    // pin level resolution
    // ************************************************************
    logic [1:0] float_reg = 2'b01;
    // undriven and unpulled pins wander every cycle
    always @(posedge clk_sys_i) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            if (pin_oe_i[k]) begin
                pin_level_o[k] = pin_drive_i[k];
            end else if (ext_en_i[k]) begin
                pin_level_o[k] = ext_level_i[k];
            end else if (pullup_on_i[k]) begin
                pin_level_o[k] = 1'b1;
            end else begin
                pin_level_o[k] = float_reg[k];
            end
        end
    end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the two pin gpio port
`timescale 1ns/1ps
module tb_top;
    import gpio_port_pkg::*;
    logic clk_sys_i, reset_i, wr_i, rd_i, rd_rmw_i, pin_state_i, stby_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [1:0] pin_i, pin_o, pin_oe_o, pullup_on_o, ext_en, ext_level;
    int fails = 0;
    int n_compared = 0;
    two_pin_gpio_port two_pin_gpio_port_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rd_rmw_i(rd_rmw_i),
        .rdata_o(rdata_o), .standby_pin_state_bit_i(pin_state_i), .standby_mode_i(stby_i),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_on_o(pullup_on_o));
    board_model board_model_inst (.clk_sys_i(clk_sys_i), .pin_drive_i(pin_o),
        .pin_oe_i(pin_oe_o), .pullup_on_i(pullup_on_o), .ext_en_i(ext_en),
        .ext_level_i(ext_level), .pin_level_o(pin_i));
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic m, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        rd_rmw_i <= m;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        rd_rmw_i <= 1'b0;
        #1 check(rdata_o, exp);
    endtask
    task automatic pins(input logic [1:0] oe, input logic [1:0] pu);
        #1 check({6'h00, pin_oe_o}, {6'h00, oe});
        check({6'h00, pullup_on_o}, {6'h00, pu});
    endtask
    // ************************************************************
    // clock and watchdog
    // ************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        tick(5000);
        fails++;
        tally_and_finish;
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        reset_i = 1'b1;
        {wr_i, rd_i, rd_rmw_i, pin_state_i, stby_i} = 5'h00;
        {addr_i, wdata_i} = 16'h0000;
        {ext_en, ext_level} = 4'h0;
        tick(6);
        reset_i <= 1'b0;
        chk(direction_offset, 1'b0, 8'h00);
        chk(latch_offset, 1'b1, 8'h00);
        pins(2'b00, 2'b00);
        wr(direction_offset, 8'hff);
        chk(direction_offset, 1'b0, 8'h06);
        wr(latch_offset, 8'h04);
        tick(2);
        pins(2'b11, 2'b00);
        check({6'h00, pin_o}, 8'h02);
        chk(latch_offset, 1'b0, 8'h04);
        wr(pullup_offset, 8'hff);
        tick(2);
        pins(2'b11, 2'b10);
        chk(pullup_offset, 1'b0, 8'h06);
        wr(direction_offset, 8'h00);
        ext_en <= 2'b11;
        ext_level <= 2'b10;
        wr(latch_offset, 8'h02);
        tick(4);
        pins(2'b00, 2'b11);
        chk(latch_offset, 1'b0, 8'h04);
        chk(latch_offset, 1'b1, 8'h02);
        chk(8'h05, 1'b0, 8'h00);
        wr(8'h05, 8'hff);
        chk(latch_offset, 1'b1, 8'h02);
        chk(direction_offset, 1'b0, 8'h00);
        chk(pullup_offset, 1'b0, 8'h06);
        wr(direction_offset, 8'h06);
        wr(latch_offset, 8'h06);
        stby_i <= 1'b1;
        tick(4);
        pins(2'b11, 2'b11);
        check({6'h00, pin_o}, 8'h03);
        tick(1);
        pin_state_i <= 1'b1;
        tick(3);
        pins(2'b00, 2'b11);
        wr(direction_offset, 8'h00);
        tick(4);
        chk(latch_offset, 1'b0, 8'h00);
        tick(1);
        stby_i <= 1'b0;
        tick(6);
        chk(latch_offset, 1'b0, 8'h04);
        wr(pullup_offset, 8'h00);
        tick(2);
        pins(2'b00, 2'b00);
        wr(direction_offset, 8'h02);
        reset_i <= 1'b1;
        tick(2);
        reset_i <= 1'b0;
        chk(direction_offset, 1'b0, 8'h00);
        tally_and_finish;
    end
endmodule
